/* design/ica_crc_byte.sv */
`timescale 1ns/1ps
// One byte step of the unreflected 16-bit cyclic code
module ica_crc_byte (
   // Running value
   input  wire logic [15:0] crcIn,
   input  wire logic [7:0]  dataByte,
   // Updated value
   output logic [15:0]      crcOut
);
   always_comb begin
      logic [15:0] c;
      c = crcIn ^ {dataByte, 8'h00};
      for (int i = 0; i < 8; i++) begin
         c = c[15] ? ((c << 1) ^ ica_pkg::CRC_POLY) : (c << 1);
      end
      crcOut = c;
   end
endmodule : ica_crc_byte

/* design/ica_pkg.sv */
package ica_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses, one word each)
   localparam logic [7:0] ADDR_GLOBAL   = 8'h00;
   localparam logic [7:0] ADDR_SELECT   = 8'h04;
   localparam logic [7:0] ADDR_ENABLE   = 8'h08;
   localparam logic [7:0] ADDR_ENMASK   = 8'h0C;
   localparam logic [7:0] ADDR_SEQ      = 8'h10;
   localparam logic [7:0] ADDR_SNAPSHOT = 8'h14;
   localparam logic [7:0] ADDR_LASTCRC  = 8'h18;
   localparam logic [7:0] ADDR_STATUS   = 8'h1C;

   // Chunk kinds selected through the select register
   localparam logic [1:0] KIND_LINES = 2'h0;
   localparam logic [1:0] KIND_CRC   = 2'h1;
   localparam logic [1:0] KIND_SET   = 2'h2;

   // Enable mask bit positions
   localparam int EN_LINES = 0;
   localparam int EN_CRC   = 1;
   localparam int EN_SET   = 2;

   // Snapshot word layout
   localparam int SNAP_IN_LSB  = 0;
   localparam int SNAP_OUT_LSB = 16;

   // Checksum definition
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'h0000;

   // Reset values
   localparam logic [2:0]  ENMASK_RESET = 3'h0;
   localparam logic [31:0] WORD_RESET   = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_IMAGE = 3'b001,
      ST_LINES = 3'b010,
      ST_SET   = 3'b011,
      ST_CRC   = 3'b100
   } ica_state_type;

endpackage : ica_pkg

/* design/ica_sync2.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for pin levels
module ica_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0]      syncOut
);
   logic [WIDTH-1:0] stage1Reg;
   // First stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stage1Reg <= '0;
         syncOut   <= '0;
      end else begin
         stage1Reg <= asyncIn;
         syncOut   <= stage1Reg;
      end
   end
endmodule : ica_sync2

/* design/image_chunk_appender.sv */
`timescale 1ns/1ps
// How it works
// - With the line snapshot enabled, all line levels are caught at each trigger and sent as a chunk of that image.
// - The snapshot is one 32-bit word with fixed bit positions per line.
// - A snapshot bit is 0 for a low line and 1 for a high line at trigger time.
// - Enabling any chunk kind is refused while the global append mode is off.
// - Turning the global append mode off clears every chunk enable at once.
// - Software selects a kind and writes its enable true; from then every image carries that chunk.
// - With the checksum enabled, an X-modem cyclic code of each image is appended as a chunk.
// - The checksum covers image data and all other chunks, not itself.
// - Padding words inside the image payload are fed into the checksum too.
// - The checksum chunk is always the last element of the payload.
// - With the set index enabled, the number of the parameter set used for the frame is appended.
// - The set index chunk may be enabled only while the sequencer is enabled.
module image_chunk_appender #(
   parameter int NUM_IN  = 2,
   parameter int NUM_OUT = 4,
   parameter int SET_W   = 4
) (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,

   // AHB-Lite slave
   input  wire logic               hsel,
   input  wire logic [7:0]         haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic [31:0]             hrdata,
   output logic                    hreadyout,
   output logic                    hresp,

   // Camera lines, asynchronous pins
   // Levels may move at any moment, hence the two flops inside
   input  wire logic [NUM_IN-1:0]  lineIn,
   input  wire logic [NUM_OUT-1:0] lineOut,

   // Acquisition side, same clock
   input  wire logic               acqTrigger,
   input  wire logic               sequencerEnable,
   input  wire logic [SET_W-1:0]   activeSetNumber,

   // Image data in, padding included
   input  wire logic               imgValid,
   input  wire logic [31:0]        imgData,
   input  wire logic               imgLast,
   output logic                    imgReady,

   // Payload stream out
   output logic                    outValid,
   output logic [31:0]             outData,
   output logic                    outLast,
   output logic                    outIsChunk,
   input  wire logic               outReady
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      // Software settings
      logic                 globalEnable;
      logic [1:0]           kindSelect;
      logic [2:0]           enMask;
      // Per-frame copies, frozen at the first image word
      logic [2:0]           frameMask;
      // Caught at the trigger, then copied per frame at the first image word
      logic [31:0]          trigSnap;
      logic [SET_W-1:0]     trigSet;
      logic [31:0]          frameSnap;
      logic [SET_W-1:0]     frameSet;
      // Running checksum and the last one sent
      logic [15:0]          crc;
      logic [15:0]          lastCrc;
      logic                 refused;
      // Payload sequencer and output word
      ica_pkg::ica_state_type st;
      logic                 outValid;
      logic [31:0]          outData;
      logic                 outLast;
      logic                 outIsChunk;
      // Bus data phase bookkeeping
      logic                 dPending;
      logic                 dWrite;
      logic [7:0]           dAddr;
      logic [31:0]          rdata;
   } ica_regs_type;

   ica_regs_type stateReg;
   ica_regs_type stateNext;

   logic [NUM_IN-1:0]  lineInSync;
   logic [NUM_OUT-1:0] lineOutSync;
   logic [31:0]        liveSnap;
   logic [15:0]        crcB0;
   logic [15:0]        crcB1;
   logic [15:0]        crcB2;
   logic [15:0]        crcWord;
   logic [31:0]        crcFeed;
   logic               outFree;
   logic               accept;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // Two cycles of latency, so a trigger sees levels two clocks old
   ica_sync2 #(.WIDTH(NUM_IN)) uSyncIn (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .asyncIn (lineIn),
      .syncOut (lineInSync)
   );

   ica_sync2 #(.WIDTH(NUM_OUT)) uSyncOut (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .asyncIn (lineOut),
      .syncOut (lineOutSync)
   );

   // Fixed positions, spare bits stay zero
   always_comb begin
      liveSnap = ica_pkg::WORD_RESET;
      liveSnap[ica_pkg::SNAP_IN_LSB +: NUM_IN]   = lineInSync;
      liveSnap[ica_pkg::SNAP_OUT_LSB +: NUM_OUT] = lineOutSync;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checksum, one word (four bytes, high byte first) per cycle

   // Four byte steps in a chain trade logic depth for one word per clock
   ica_crc_byte uCrc0 (.crcIn(stateReg.crc), .dataByte(crcFeed[31:24]), .crcOut(crcB0));
   ica_crc_byte uCrc1 (.crcIn(crcB0),        .dataByte(crcFeed[23:16]), .crcOut(crcB1));
   ica_crc_byte uCrc2 (.crcIn(crcB1),        .dataByte(crcFeed[15:8]),  .crcOut(crcB2));
   ica_crc_byte uCrc3 (.crcIn(crcB2),        .dataByte(crcFeed[7:0]),   .crcOut(crcWord));

   // Output register can take a word when empty or being drained
   assign outFree  = !stateReg.outValid || outReady;
   assign imgReady = outFree && (stateReg.st == ica_pkg::ST_IMAGE);
   assign accept   = imgValid && imgReady;

   // Word fed to the checksum in the current state
   always_comb begin
      unique case (stateReg.st)
         ica_pkg::ST_IMAGE: crcFeed = imgData;
         ica_pkg::ST_LINES: crcFeed = stateReg.frameSnap;
         ica_pkg::ST_SET:   crcFeed = {{(32-SET_W){1'b0}}, stateReg.frameSet};
         default:           crcFeed = ica_pkg::WORD_RESET;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      logic [2:0] wantMask;
      logic       wrEnable;
      logic [1:0] nextKind;
      wantMask = stateReg.enMask;
      wrEnable = 1'b0;
      nextKind = ica_pkg::KIND_LINES;
      stateNext = stateReg;

      // Bus data phase: write lands, read answered from the registered word
      if (stateReg.dPending && stateReg.dWrite) begin
         unique case (stateReg.dAddr)
            ica_pkg::ADDR_GLOBAL: begin
               stateNext.globalEnable = hwdata[0];
               if (!hwdata[0]) begin
                  wantMask = ica_pkg::ENMASK_RESET;
               end
            end
            ica_pkg::ADDR_SELECT: stateNext.kindSelect = hwdata[1:0];
            ica_pkg::ADDR_ENABLE: begin
               wrEnable = 1'b1;
               if (!hwdata[0]) begin
                  wantMask[stateReg.kindSelect] = 1'b0;
               end else if (!stateReg.globalEnable) begin
                  stateNext.refused = 1'b1;
               end else if (stateReg.kindSelect == ica_pkg::KIND_SET && !sequencerEnable) begin
                  stateNext.refused = 1'b1;
               end else if (stateReg.kindSelect <= ica_pkg::KIND_SET) begin
                  wantMask[stateReg.kindSelect] = 1'b1;
                  stateNext.refused = 1'b0;
               end else begin
                  stateNext.refused = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Sequencer switched off drops the set index chunk
      if (!sequencerEnable) begin
         wantMask[ica_pkg::EN_SET] = 1'b0;
      end
      stateNext.enMask = wantMask;
      if (wrEnable) begin
         stateNext.enMask = wantMask;
      end

      // Zero wait states: the read word is fetched at the address edge
      // Bus address phase
      stateNext.dPending = hsel && hready && htrans[1];
      if (hsel && hready && htrans[1]) begin
         stateNext.dWrite = hwrite;
         stateNext.dAddr  = {haddr[7:2], 2'b00};
         unique case ({haddr[7:2], 2'b00})
            ica_pkg::ADDR_GLOBAL:   stateNext.rdata = {31'h0, stateReg.globalEnable};
            ica_pkg::ADDR_SELECT:   stateNext.rdata = {30'h0, stateReg.kindSelect};
            // Kind 3 has no enable bit; reading it must not give an unknown
            ica_pkg::ADDR_ENABLE:   stateNext.rdata = {31'h0, (stateReg.kindSelect <= ica_pkg::KIND_SET)
                                                       && stateReg.enMask[stateReg.kindSelect]};
            ica_pkg::ADDR_ENMASK:   stateNext.rdata = {29'h0, stateReg.enMask};
            ica_pkg::ADDR_SEQ:      stateNext.rdata = {{(32-SET_W){1'b0}}, activeSetNumber};
            ica_pkg::ADDR_SNAPSHOT: stateNext.rdata = stateReg.frameSnap;
            ica_pkg::ADDR_LASTCRC:  stateNext.rdata = {16'h0, stateReg.lastCrc};
            ica_pkg::ADDR_STATUS:   stateNext.rdata = {28'h0, stateReg.st != ica_pkg::ST_IDLE,
                                                       sequencerEnable, stateReg.refused, stateReg.globalEnable};
            default:                stateNext.rdata = ica_pkg::WORD_RESET;
         endcase
      end

      // Trigger catches line levels and the active set number
      if (acqTrigger) begin
         stateNext.trigSnap = liveSnap;
         stateNext.trigSet  = activeSetNumber;
      end

      // Output register drains
      if (stateReg.outValid && outReady) begin
         stateNext.outValid = 1'b0;
      end

      // Payload sequencing
      unique case (stateReg.st)
         ica_pkg::ST_IDLE: begin
            // Enables are latched per frame so a mid-frame write cannot tear it
            if (imgValid) begin
               stateNext.frameMask = stateReg.enMask;
               stateNext.frameSnap = stateReg.trigSnap;
               stateNext.frameSet  = stateReg.trigSet;
               stateNext.crc       = ica_pkg::CRC_INIT;
               stateNext.st        = ica_pkg::ST_IMAGE;
            end
         end

         // Image words pass straight through, padding included
         ica_pkg::ST_IMAGE: begin
            if (accept) begin
               stateNext.crc        = crcWord;
               stateNext.outValid   = 1'b1;
               stateNext.outData    = imgData;
               stateNext.outIsChunk = 1'b0;
               stateNext.outLast    = imgLast && (stateReg.frameMask == 3'h0);
               if (imgLast) begin
                  if (stateReg.frameMask[ica_pkg::EN_LINES]) begin
                     nextKind = ica_pkg::KIND_LINES;
                     stateNext.st = ica_pkg::ST_LINES;
                  end else if (stateReg.frameMask[ica_pkg::EN_SET]) begin
                     stateNext.st = ica_pkg::ST_SET;
                  end else if (stateReg.frameMask[ica_pkg::EN_CRC]) begin
                     stateNext.st = ica_pkg::ST_CRC;
                  end else begin
                     stateNext.st = ica_pkg::ST_IDLE;
                  end
               end
            end
         end

         // One word per chunk: lines, then set index, then checksum
         ica_pkg::ST_LINES: begin
            if (outFree) begin
               stateNext.crc        = crcWord;
               stateNext.outValid   = 1'b1;
               stateNext.outData    = stateReg.frameSnap;
               stateNext.outIsChunk = 1'b1;
               stateNext.outLast    = !stateReg.frameMask[ica_pkg::EN_SET] && !stateReg.frameMask[ica_pkg::EN_CRC];
               if (stateReg.frameMask[ica_pkg::EN_SET]) begin
                  stateNext.st = ica_pkg::ST_SET;
               end else if (stateReg.frameMask[ica_pkg::EN_CRC]) begin
                  stateNext.st = ica_pkg::ST_CRC;
               end else begin
                  stateNext.st = ica_pkg::ST_IDLE;
               end
            end
         end

         // Set number is zero-extended to a full word
         ica_pkg::ST_SET: begin
            if (outFree) begin
               stateNext.crc        = crcWord;
               stateNext.outValid   = 1'b1;
               stateNext.outData    = {{(32-SET_W){1'b0}}, stateReg.frameSet};
               stateNext.outIsChunk = 1'b1;
               stateNext.outLast    = !stateReg.frameMask[ica_pkg::EN_CRC];
               stateNext.st         = stateReg.frameMask[ica_pkg::EN_CRC] ? ica_pkg::ST_CRC : ica_pkg::ST_IDLE;
            end
         end

         ica_pkg::ST_CRC: begin
            // Checksum goes last and is not fed into itself
            if (outFree) begin
               stateNext.outValid   = 1'b1;
               stateNext.outData    = {16'h0, stateReg.crc};
               stateNext.outIsChunk = 1'b1;
               stateNext.outLast    = 1'b1;
               stateNext.lastCrc    = stateReg.crc;
               stateNext.st         = ica_pkg::ST_IDLE;
            end
         end
         default: stateNext.st = ica_pkg::ST_IDLE;
      endcase
      if (nextKind != ica_pkg::KIND_LINES) begin
         stateNext.st = ica_pkg::ST_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   // Synchronous reset clears every field, enables included
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stateReg <= '0;
      end else begin
         stateReg <= stateNext;
      end
   end

   // Outputs from flops; slave always ready and OKAY
   assign hrdata     = stateReg.rdata;
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign outValid   = stateReg.outValid;
   assign outData    = stateReg.outData;
   assign outLast    = stateReg.outLast;
   assign outIsChunk = stateReg.outIsChunk;

endmodule : image_chunk_appender

/* testbench/ica_asserts.sv */
`timescale 1ns/1ps
module ica_asserts #(
   parameter int NUM_IN  = 2,
   parameter int NUM_OUT = 4,
   parameter int SET_W   = 4
) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // Bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Acquisition and stream
   input wire logic        sequencerEnable,
   input wire logic        outValid,
   input wire logic [31:0] outData,
   input wire logic        outLast,
   input wire logic        outIsChunk,
   input wire logic        outReady
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic       wrPend;
   logic [7:0] wrAddr;
   logic       globalOn;
   logic       inChunks;
   logic       rdPhase;
   assign rdPhase = hsel && hready && htrans[1] && !hwrite;
   // Shadows rebuilt from port traffic only, so a stuck register inside shows up
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wrPend   <= 1'b0;
         wrAddr   <= 8'h00;
         globalOn <= 1'b0;
         inChunks <= 1'b0;
      end else begin
         wrPend <= hsel && hready && htrans[1] && hwrite;
         wrAddr <= haddr;
         if (wrPend && wrAddr == ica_pkg::ADDR_GLOBAL) begin
            globalOn <= hwdata[0];
         end
         if (outValid && outReady) begin
            inChunks <= outIsChunk && !outLast;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_bus_okay_ready: assert property (hreadyout && !hresp) else $error("bus wait or error seen");
   a_out_stall_hold: assert property (outValid && !outReady |=> outValid && $stable(outData)
      && $stable(outLast) && $stable(outIsChunk)) else $error("stalled word changed");
   a_chunk_tail_only: assert property (inChunks && outValid |-> outIsChunk) else $error("image after chunk");
   a_last_closes_frame: assert property (outValid && outReady && outLast |=> !outValid)
      else $error("word right after frame end");
   a_unmapped_zero: assert property (rdPhase && haddr > ica_pkg::ADDR_STATUS |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_snap_spare_zero: assert property (rdPhase && haddr == ica_pkg::ADDR_SNAPSHOT |=>
      hrdata[15:NUM_IN] == '0 && hrdata[31:16+NUM_OUT] == '0) else $error("spare snapshot bit set");
   a_global_off_mask: assert property (rdPhase && haddr == ica_pkg::ADDR_ENMASK && !globalOn
      |=> hrdata[2:0] == 3'h0) else $error("chunk enabled while global off");
   a_set_needs_seq: assert property (rdPhase && haddr == ica_pkg::ADDR_ENMASK && !sequencerEnable
      && !$past(sequencerEnable) && !$past(sequencerEnable, 2) |=> !hrdata[ica_pkg::EN_SET])
      else $error("set index enabled without sequencer");
endmodule : ica_asserts

/* testbench/ica_host_model.sv */
`timescale 1ns/1ps
module ica_host_model (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // Payload stream from the camera
   input wire logic        outValid,
   input wire logic [31:0] outData,
   input wire logic        outLast,
   output logic            outReady,
   // Host settings and verdicts
   input wire logic        slowMode,
   input wire logic        crcExpected,
   output int              nPass,
   output int              nCorrupt
);
   int          seed = 32'h70A6B708;
   logic [15:0] run;
   // Unreflected step over one word, high byte first
   function automatic logic [15:0] crcWord(input logic [15:0] c, input logic [31:0] w);
      for (int b = 31; b >= 0; b--) begin
         c = (c[15] ^ w[b]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
      end
      return c;
   endfunction : crcWord
   // A slow host drops ready at random to stall the stream
   always @(posedge clk_sys) begin
      outReady <= sys_rst ? 1'b0 : (!slowMode || $random(seed) % 3 != 0);
   end
   // Recompute over all but the last word, then judge the trailing checksum
   always @(negedge clk_sys) begin
      if (sys_rst) begin
         run = 16'h0000;
         nPass = 0;
         nCorrupt = 0;
      end else if (outValid && outReady) begin
         if (outLast && crcExpected) begin
            if (outData[15:0] == run) nPass++;
            else nCorrupt++;
         end
         run = outLast ? 16'h0000 : crcWord(run, outData);
      end
   end
endmodule : ica_host_model

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
   localparam int NUM_IN = 2;
   localparam int NUM_OUT = 4;
   localparam int SET_W = 4;
   logic               clk_sys, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0]         haddr;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   logic [31:0]        hwdata, hrdata, imgData, outData, snapLast, crcLast;
   logic [NUM_IN-1:0]  lineIn;
   logic [NUM_OUT-1:0] lineOut;
   logic [SET_W-1:0]   activeSetNumber;
   logic               acqTrigger, sequencerEnable, imgValid, imgLast, imgReady;
   logic               outValid, outLast, outIsChunk, outReady, slowMode, crcExpected;
   int                 nPass, nCorrupt, failures, n_compared, seed;
   logic [33:0]        expQ[$];
   assign hready = hreadyout;
   image_chunk_appender #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT), .SET_W(SET_W)) image_chunk_appender_i (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .lineIn(lineIn), .lineOut(lineOut), .acqTrigger(acqTrigger), .sequencerEnable(sequencerEnable),
      .activeSetNumber(activeSetNumber), .imgValid(imgValid), .imgData(imgData), .imgLast(imgLast),
      .imgReady(imgReady), .outValid(outValid), .outData(outData), .outLast(outLast),
      .outIsChunk(outIsChunk), .outReady(outReady));
   ica_host_model ica_host_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .outValid(outValid),
      .outData(outData), .outLast(outLast), .outReady(outReady), .slowMode(slowMode),
      .crcExpected(crcExpected), .nPass(nPass), .nCorrupt(nCorrupt));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Settled level seen at the falling edge decides the coming rising edge
   task automatic hold(input bit img, output logic [31:0] r);
      @(negedge clk_sys);
      while (!(img ? imgReady : hready)) @(negedge clk_sys);
      @(posedge clk_sys);
      r = hrdata;
   endtask : hold
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      hold(1'b0, r);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold(1'b0, r);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check({2'h0, r}, {2'h0, e});
   endtask : rd
   // Trigger, then one frame; the model queue gets image words and chunks
   task automatic frame(input int n, input logic [2:0] en);
      logic [NUM_IN-1:0]  li;
      logic [NUM_OUT-1:0] lo;
      logic [SET_W-1:0]   sn;
      logic [32:0]        q[$];
      logic [15:0]        c;
      logic [31:0]        w;
      li = $random(seed);
      lo = $random(seed);
      sn = $random(seed);
      lineIn <= li;
      lineOut <= lo;
      activeSetNumber <= sn;
      crcExpected <= en[ica_pkg::EN_CRC];
      repeat (4) @(posedge clk_sys);
      acqTrigger <= 1'b1;
      @(posedge clk_sys);
      acqTrigger <= 1'b0;
      lineIn <= ~li;
      lineOut <= ~lo;
      c = ica_pkg::CRC_INIT;
      for (int i = 0; i < n; i++) q.push_back({1'b0, 32'($random(seed))});
      if (en[ica_pkg::EN_LINES]) q.push_back({1'b1, 12'h0, lo, 14'h0, li});
      if (en[ica_pkg::EN_SET]) q.push_back({1'b1, 28'h0, sn});
      foreach (q[i]) c = ica_host_model_i.crcWord(c, q[i][31:0]);
      if (en[ica_pkg::EN_CRC]) q.push_back({1'b1, 16'h0, c});
      if (en[ica_pkg::EN_CRC]) crcLast = {16'h0, c};
      foreach (q[i]) expQ.push_back({q[i][32], i == q.size() - 1, q[i][31:0]});
      for (int i = 0; i < n; i++) begin
         imgValid <= 1'b1;
         imgData <= q[i][31:0];
         imgLast <= (i == n - 1);
         hold(1'b1, w);
      end
      imgValid <= 1'b0;
      imgLast <= 1'b0;
      for (int t = 0; t < 300 && expQ.size() > 0; t++) @(posedge clk_sys);
      check(34'(expQ.size()), 34'h0);
      snapLast = {12'h0, lo, 14'h0, li};
   endtask : frame
   // Each word taken by the host is matched against the model
   always @(negedge clk_sys) begin
      if (!sys_rst && outValid && outReady) begin
         check({outIsChunk, outLast, outData}, expQ.size() > 0 ? expQ.pop_front() : {34{1'bx}});
      end
   end
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // Watchdog sized well beyond the whole sequence
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      $display("timeout reached");
      end_of_test();
   end
   initial begin
      seed = 32'h70A6B708;
      {sys_rst, hsel, hwrite, haddr, htrans, hwdata, hsize} = {1'b1, 44'h0, 3'h2};
      {lineIn, lineOut, acqTrigger, sequencerEnable, activeSetNumber} = '0;
      {imgValid, imgData, imgLast, slowMode, crcExpected} = '0;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(ica_pkg::ADDR_ENMASK, 32'h0);
      rd(ica_pkg::ADDR_STATUS, 32'h0);
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'h0);
      wr(ica_pkg::ADDR_SELECT, 32'(ica_pkg::KIND_LINES));
      wr(ica_pkg::ADDR_ENABLE, 32'h1);
      rd(ica_pkg::ADDR_ENMASK, 32'h0);
      rd(ica_pkg::ADDR_STATUS, 32'h2);
      $display("test refusal done");
      wr(ica_pkg::ADDR_GLOBAL, 32'h1);
      for (int k = 0; k < 3; k++) begin
         wr(ica_pkg::ADDR_SELECT, 32'(k));
         wr(ica_pkg::ADDR_ENABLE, 32'h1);
      end
      rd(ica_pkg::ADDR_ENMASK, 32'h3);
      sequencerEnable <= 1'b1;
      wr(ica_pkg::ADDR_SELECT, 32'(ica_pkg::KIND_SET));
      wr(ica_pkg::ADDR_ENABLE, 32'h1);
      wr(ica_pkg::ADDR_SELECT, 32'h3);
      wr(ica_pkg::ADDR_ENABLE, 32'h1);
      rd(ica_pkg::ADDR_ENABLE, 32'h0);
      rd(ica_pkg::ADDR_ENMASK, 32'h7);
      rd(ica_pkg::ADDR_STATUS, 32'h7);
      $display("test enables done");
      slowMode <= 1'b1;
      frame(5, 3'h7);
      rd(ica_pkg::ADDR_SNAPSHOT, snapLast);
      slowMode <= 1'b0;
      wr(ica_pkg::ADDR_SELECT, 32'(ica_pkg::KIND_LINES));
      wr(ica_pkg::ADDR_ENABLE, 32'h0);
      frame(1, 3'h6);
      sequencerEnable <= 1'b0;
      rd(ica_pkg::ADDR_ENMASK, 32'h2);
      slowMode <= 1'b1;
      frame(3, 3'h2);
      rd(ica_pkg::ADDR_LASTCRC, crcLast);
      rd(ica_pkg::ADDR_SEQ, 32'(activeSetNumber));
      wr(ica_pkg::ADDR_GLOBAL, 32'h0);
      rd(ica_pkg::ADDR_ENMASK, 32'h0);
      frame(4, 3'h0);
      check(34'(nPass), 34'h3);
      check(34'(nCorrupt), 34'h0);
      $display("test frames done");
      end_of_test();
   end
endmodule : tb
bind image_chunk_appender ica_asserts #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT), .SET_W(SET_W)) ica_asserts_i (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .sequencerEnable(sequencerEnable), .outValid(outValid), .outData(outData), .outLast(outLast),
   .outIsChunk(outIsChunk), .outReady(outReady));
